// ### logic/csl_pkg.sv
// package for the cascadable serial-in output latch and its host
package csl_pkg;
	localparam int CSL_WIDTH = 8;
	localparam int CSL_STAGES = 2;
	localparam int CSL_DIV = 2;
	localparam logic [7:0] CSL_ZERO = 8'h00;
	localparam logic [7:0] CSL_DIM_FULL = 8'hFF;
	localparam logic [7:0] CSL_CNT_ONE = 8'h01;
	localparam logic [7:0] CSL_CNT_ZERO = 8'h00;
endpackage : csl_pkg

// ### logic/csl_link_if.sv
// link between host and cascadable output latch
`timescale 1ns/1ns
`default_nettype none
interface csl_link_if;
	logic shift_clock_in;
	logic latch_clock;
	logic register_wipe_n;
	logic output_gate_n;
	logic chain_data_in;
	logic chain_data_out;
	modport dev_mp (
		input shift_clock_in,
		input latch_clock,
		input register_wipe_n,
		input output_gate_n,
		input chain_data_in,
		output chain_data_out
	);
	modport host_mp (
		output shift_clock_in,
		output latch_clock,
		output register_wipe_n,
		output output_gate_n,
		output chain_data_in,
		input chain_data_out
	);
endinterface : csl_link_if
`default_nettype wire

// ### logic/csl_device.sv
// cascadable serial-in, parallel-out latch with open-drain sink outputs
// Summary of operation
// - eight-stage chain shifts on rising shift clock
// - latch clock rise copies chain into latch
// - latch feeds outputs only while wipe high
// - wipe low zeroes chain and latch
// - controller wipes at power-up
// - gate high forces all sink outputs off; latch and cascade output keep their values
// - gate low makes outputs follow latch
// - bit one sinks current, zero off
// - controller may pulse gate for dimming
// - cascade output updates on falling shift edge
// - cascade output feeds next stage input
// - host shifts all bits, then pulses latch
// - latched one turns load on when gated
`timescale 1ns/1ns
`default_nettype none
module csl_device
	import csl_pkg::*;
#(
	parameter int WIDTH = CSL_WIDTH
)
(
	// link side
	csl_link_if.dev_mp link,
	// sink outputs, open-drain: oe high means pulling low
	output logic [WIDTH-1:0] sink_o,
	output logic [WIDTH-1:0] sink_oe_o,
	// latched word, for observation
	output logic [WIDTH-1:0] latch_o
);
	logic [WIDTH-1:0] chain_reg;
	logic [WIDTH-1:0] chain_next;
	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] latch_next;
	logic out_reg;
	logic out_next;
	logic [WIDTH-1:0] buf_w;

	// chain next value: shift toward msb, serial bit enters lsb
	always_comb
	begin
		chain_next = {chain_reg[WIDTH-2:0], link.chain_data_in};
	end

	// wipe is asynchronous by nature of the pin; it beats any clock edge
	always_ff @(posedge link.shift_clock_in or negedge link.register_wipe_n)
	begin
		if (!link.register_wipe_n)
			chain_reg <= '0;
		else
			chain_reg <= chain_next;
	end

	// latch next value: parallel copy of the chain
	always_comb
	begin
		latch_next = chain_reg;
	end

	always_ff @(posedge link.latch_clock or negedge link.register_wipe_n)
	begin
		if (!link.register_wipe_n)
			latch_reg <= '0;
		else
			latch_reg <= latch_next;
	end

	// cascade next value: the far end of the chain
	always_comb
	begin
		out_next = chain_reg[WIDTH-1];
	end

	// cascade bit moves on the falling edge for hold margin downstream
	always_ff @(negedge link.shift_clock_in or negedge link.register_wipe_n)
	begin
		if (!link.register_wipe_n)
			out_reg <= 1'b0;
		else
			out_reg <= out_next;
	end

	// output buffer is transparent, no clock between latch and pins
	always_comb
	begin
		if (link.output_gate_n || !link.register_wipe_n)
			buf_w = '0;
		else
			buf_w = latch_reg;
	end

	assign link.chain_data_out = out_reg;
	assign sink_o = '0; // drain only ever pulls low
	assign sink_oe_o = buf_w;
	assign latch_o = latch_reg;
endmodule : csl_device
`default_nettype wire

// ### logic/csl_host.sv
// host end: shifts a word chain out and pulses the latch clock
`timescale 1ns/1ns
`default_nettype none
module csl_host
	import csl_pkg::*;
#(
	parameter int WIDTH = CSL_WIDTH,
	parameter int STAGES = CSL_STAGES,
	parameter int DIV = CSL_DIV
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// user request
	input wire logic load_valid_i,
	input wire logic [WIDTH*STAGES-1:0] load_data_i,
	output logic load_ready_o,
	input wire logic wipe_req_i,
	input wire logic [7:0] dim_level_i,
	// cascade readback
	output logic [WIDTH*STAGES-1:0] chain_back_o,
	// link side
	csl_link_if.host_mp link
);
	localparam int NBITS = WIDTH * STAGES;
	typedef enum logic [2:0] {CSL_IDLE, CSL_LOW, CSL_HIGH, CSL_LATCH, CSL_WIPE} csl_state_e;

	csl_state_e state_reg, state_next;
	logic [NBITS-1:0] sh_reg, sh_next;
	logic [NBITS-1:0] back_reg, back_next;
	logic [15:0] bit_reg, bit_next;
	logic [15:0] div_reg, div_next;
	logic sck_reg, sck_next;
	logic rck_reg, rck_next;
	logic wipe_n_reg, wipe_n_next;
	logic din_reg, din_next;
	logic [7:0] pwm_reg, pwm_next;
	logic gate_n_reg, gate_n_next;
	logic sync1_reg, sync2_reg;
	logic tick;

	// cascade return from the link domain, two flops before use
	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= link.chain_data_out;
			sync2_reg <= sync1_reg;
		end
	end

	assign tick = (div_reg == 16'(DIV - 1));

	// sequencer: each bit is a low then high half period
	always_comb
	begin
		state_next = state_reg;
		sh_next = sh_reg;
		back_next = back_reg;
		bit_next = bit_reg;
		div_next = tick ? 16'h0000 : div_reg + 16'h0001;
		sck_next = sck_reg;
		rck_next = 1'b0;
		wipe_n_next = 1'b1;
		din_next = din_reg;
		pwm_next = pwm_reg + CSL_CNT_ONE;
		gate_n_next = !(pwm_reg < dim_level_i || dim_level_i == CSL_DIM_FULL);
		case (state_reg)
			CSL_IDLE:
			begin
				div_next = 16'h0000;
				if (wipe_req_i)
				begin
					wipe_n_next = 1'b0;
					state_next = CSL_WIPE;
				end
				else if (load_valid_i)
				begin
					sh_next = load_data_i;
					bit_next = 16'h0000;
					state_next = CSL_LOW;
				end
			end
			CSL_LOW:
				if (tick)
				begin
					sck_next = 1'b1;
					din_next = din_reg;
					state_next = CSL_HIGH;
				end
				else if (div_reg == 16'h0000)
					din_next = sh_reg[NBITS-1];
			CSL_HIGH:
				if (tick)
				begin
					sck_next = 1'b0;
					sh_next = {sh_reg[NBITS-2:0], 1'b0};
					back_next = {back_reg[NBITS-2:0], sync2_reg};
					bit_next = bit_reg + 16'h0001;
					state_next = (bit_reg == 16'(NBITS - 1)) ? CSL_LATCH : CSL_LOW;
				end
			CSL_LATCH:
			begin
				rck_next = 1'b1;
				state_next = CSL_IDLE;
			end
			CSL_WIPE:
				state_next = CSL_IDLE;
			default:
				state_next = CSL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= CSL_WIPE;
			sh_reg <= '0;
			back_reg <= '0;
			bit_reg <= 16'h0000;
			div_reg <= 16'h0000;
			sck_reg <= 1'b0;
			rck_reg <= 1'b0;
			wipe_n_reg <= 1'b0;
			din_reg <= 1'b0;
			pwm_reg <= CSL_CNT_ZERO;
			gate_n_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			sh_reg <= sh_next;
			back_reg <= back_next;
			bit_reg <= bit_next;
			div_reg <= div_next;
			sck_reg <= sck_next;
			rck_reg <= rck_next;
			wipe_n_reg <= wipe_n_next;
			din_reg <= din_next;
			pwm_reg <= pwm_next;
			gate_n_reg <= gate_n_next;
		end
	end

	assign load_ready_o = (state_reg == CSL_IDLE) && !wipe_req_i;
	assign chain_back_o = back_reg;
	assign link.shift_clock_in = sck_reg;
	assign link.latch_clock = rck_reg;
	assign link.register_wipe_n = wipe_n_reg;
	assign link.output_gate_n = gate_n_reg;
	assign link.chain_data_in = din_reg;
endmodule : csl_host
`default_nettype wire

// ### dv/csl_checker.sv
// link checker between the host end and the output latch
`timescale 1ns/1ns
`default_nettype none
module csl_checker
	import csl_pkg::*;
(
	// clocks and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// link signals
	input wire logic shift_clock_in,
	input wire logic latch_clock,
	input wire logic register_wipe_n,
	input wire logic output_gate_n,
	input wire logic chain_data_in,
	input wire logic chain_data_out
);
	logic [7:0] chain_m;
	int shifts;
	// shadow chain, wiped on level just like the device
	always_ff @(posedge shift_clock_in or negedge register_wipe_n)
		if (!register_wipe_n)
			chain_m <= 8'h00;
		else
			chain_m <= {chain_m[6:0], chain_data_in};
	// shift edges since the last latch pulse
	always_ff @(posedge sys_clk_i)
		if (!resetn_i || latch_clock)
			shifts <= 0;
		else if ($rose(shift_clock_in))
			shifts <= shifts + 1;
	a_cascade_last: assert property (@(posedge shift_clock_in) disable iff (!register_wipe_n)
		chain_data_out == chain_m[7]) else $error("cascade not last stage");
	a_shift_count: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(latch_clock) |-> shifts == CSL_WIDTH * CSL_STAGES) else $error("bad shift count");
	a_latch_idle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(latch_clock) |-> !shift_clock_in) else $error("latch during shift");
	a_latch_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(latch_clock) |=> !latch_clock) else $error("latch pulse too long");
	a_data_steady: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(shift_clock_in) |-> $stable(chain_data_in)) else $error("data moved at shift");
	a_shift_high: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(shift_clock_in) |=> shift_clock_in ##1 !shift_clock_in) else $error("shift width");
	a_wipe_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		!register_wipe_n |-> !shift_clock_in && !latch_clock) else $error("clock during wipe");
	a_wipe_release: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(resetn_i) |-> !register_wipe_n && output_gate_n) else $error("no wipe at start");
	c_latch: cover property (@(posedge sys_clk_i) $rose(latch_clock));
	c_wipe: cover property (@(posedge sys_clk_i) $fell(register_wipe_n));
	c_dark: cover property (@(posedge sys_clk_i) $rose(output_gate_n));
endmodule : csl_checker
`default_nettype wire

// ### dv/tb.sv
// self-checking bench: host end driving one output latch
`timescale 1ns/1ns
`default_nettype none
module tb;
	import csl_pkg::*;
	logic sys_clk_i, resetn_i, load_valid_i, wipe_req_i, load_ready_o;
	logic [15:0] load_data_i;
	logic [7:0] dim_level_i, sink_o, sink_oe_o, latch_o;
	logic [15:0] chain_back_o;
	logic [7:0] on_cnt, prev_byte;
	int err_count, compares;
	// word sent beside the byte the near stage keeps
	logic [23:0] rows [4] = '{24'hA55A5A, 24'hFF0101, 24'h558080, 24'h0FFFFF};
	csl_link_if link0 ();
	csl_host csl_host_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.load_valid_i(load_valid_i), .load_data_i(load_data_i), .load_ready_o(load_ready_o),
		.wipe_req_i(wipe_req_i), .dim_level_i(dim_level_i), .chain_back_o(chain_back_o),
		.link(link0));
	csl_device csl_device_inst (.link(link0), .sink_o(sink_o), .sink_oe_o(sink_oe_o),
		.latch_o(latch_o));
	csl_checker csl_checker_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.shift_clock_in(link0.shift_clock_in), .latch_clock(link0.latch_clock),
		.register_wipe_n(link0.register_wipe_n), .output_gate_n(link0.output_gate_n),
		.chain_data_in(link0.chain_data_in), .chain_data_out(link0.chain_data_out));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// hand one word over, then wait (bounded) until the host is idle again
	task automatic send(input logic [15:0] w);
		int n;
		@(posedge sys_clk_i);
		load_data_i <= w;
		load_valid_i <= 1'b1;
		@(posedge sys_clk_i);
		load_valid_i <= 1'b0;
		n = 0;
		do @(negedge sys_clk_i); while (load_ready_o !== 1'b1 && ++n < 200);
		check("load_ready", {7'h00, load_ready_o}, 8'h01);
	endtask : send
	task automatic summarize();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial
	begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	// watchdog well past four loads and the gate and wipe tests
	initial
	begin
		repeat (3000) @(posedge sys_clk_i);
		err_count++;
		summarize();
	end
	initial
	begin
		{resetn_i, load_valid_i, wipe_req_i, load_data_i} = '0;
		dim_level_i = 8'hFF;
		prev_byte = 8'h00;
		repeat (16) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		check("latch_reset", latch_o, 8'h00);
		foreach (rows[i])
		begin
			send(rows[i][23:8]);
			check("latch", latch_o, rows[i][7:0]);
			check("sink", sink_oe_o, rows[i][7:0]);
			check("cascade", {7'h00, link0.chain_data_out}, {7'h00, rows[i][7]});
			check("drain_level", sink_o, 8'h00);
			check("back_far", chain_back_o[7:0], rows[i][23:16]);
			check("back_near", chain_back_o[15:8], prev_byte);
			prev_byte = rows[i][7:0];
		end
		@(posedge sys_clk_i);
		dim_level_i <= 8'h00;
		repeat (4) @(negedge sys_clk_i);
		check("sink_dark", sink_oe_o, 8'h00);
		check("latch_kept", latch_o, 8'hFF);
		// half duty: any 256-cycle window of the dimming counter is half lit
		@(posedge sys_clk_i);
		dim_level_i <= 8'h80;
		repeat (4) @(negedge sys_clk_i);
		on_cnt = 8'h00;
		repeat (256)
		begin
			@(negedge sys_clk_i);
			if (sink_oe_o == 8'hFF)
				on_cnt++;
		end
		check("dim_duty", on_cnt, 8'h80);
		check("dim_latch", latch_o, 8'hFF);
		@(posedge sys_clk_i);
		dim_level_i <= 8'hFF;
		repeat (4) @(negedge sys_clk_i);
		check("sink_back", sink_oe_o, 8'hFF);
		@(posedge sys_clk_i);
		wipe_req_i <= 1'b1;
		@(posedge sys_clk_i);
		wipe_req_i <= 1'b0;
		repeat (4) @(negedge sys_clk_i);
		check("latch_wiped", latch_o, 8'h00);
		check("sink_wiped", sink_oe_o, 8'h00);
		check("cascade_wiped", {7'h00, link0.chain_data_out}, 8'h00);
		// a load after the wipe must find the chain empty
		send(16'h3CC3);
		check("latch_after_wipe", latch_o, 8'hC3);
		check("back_wiped", chain_back_o[15:8], 8'h00);
		check("back_fresh", chain_back_o[7:0], 8'h3C);
		summarize();
	end
endmodule : tb
`default_nettype wire
